// [hw/clkgen_pkg.sv]
// Purpose: constants and types for the clock generator unit
// Assumes: register port with index addresses, 32-bit data
// Notes: frequencies are held in tenths of a kilohertz
package clkgen_pkg;
  localparam int AW = 3;
  localparam int DW = 32;
  localparam int NW = 8;
  localparam int WW = 6;
  localparam int CW = 20;
  // register indexes
  localparam logic [AW-1:0] REG_CTRL = 3'h0;
  localparam logic [AW-1:0] REG_MULT = 3'h1;
  localparam logic [AW-1:0] REG_RANGE = 3'h2;
  localparam logic [AW-1:0] REG_STATUS = 3'h3;
  localparam logic [AW-1:0] REG_CENTER = 3'h4;
  // field positions
  localparam int CTL_W = 6;
  localparam int RNG_E_LSB = 8;
  localparam int ST_LOCK = 0;
  localparam int ST_TRK = 1;
  localparam int ST_FLAG = 2;
  localparam int ST_SEL = 3;
  localparam int ST_OVER = 4;
  // reset values
  localparam logic [CTL_W-1:0] CTRL_RST = 6'h04;
  localparam logic [NW-1:0] MULT_RST = 8'h01;
  localparam logic [7:0] LIN_RST = 8'h00;
  localparam logic [1:0] EXP_RST = 2'h0;
  // lock detector: window in reference edges, tolerances in edges
  localparam logic [WW-1:0] LOCK_WIN = 6'h20;
  localparam logic [WW-1:0] TRACK_TOL = 6'h03;
  localparam logic [WW-1:0] LOCK_TOL = 6'h01;
  // nominal step 71.4 kHz, bus ceiling 8 MHz, vco is four times bus
  localparam logic [CW-1:0] NOM_STEP = 20'h002CA;
  localparam int BUS_MAX_KHZ = 8000;
  localparam logic [CW-1:0] VCO_MAX = CW'(4 * BUS_MAX_KHZ * 10);

  typedef struct packed {
    logic osc_stop;
    logic irq_en;
    logic trk_wr;
    logic auto_bw;
    logic bsel;
    logic pwr;
  } ctrl_s;

  typedef struct packed {
    ctrl_s ctl;
    logic [NW-1:0] mult_n;
    logic [7:0] lin_l;
    logic [1:0] exp_e;
    logic osc_en;
    logic xclk;
    logic rclk;
    logic rclk_d;
    logic vco_d;
    logic xdiv;
    logic vdiv;
    logic sel_act;
    logic hold;
    logic base;
    logic base_d;
    logic bus;
    logic sys;
    logic [NW-1:0] fb_cnt;
    logic fb;
    logic fb_d;
    logic up;
    logic dn;
    logic [WW-1:0] win_cnt;
    logic [WW-1:0] edges;
    logic trk_det;
    logic lock_det;
    logic lock_s1;
    logic lock_s2;
    logic lock_prev;
    logic lock_out;
    logic trk_out;
    logic irq_flag;
    logic irq;
    logic [CW-1:0] center;
    logic over;
    logic [DW-1:0] rdata;
  } state_s;

  function automatic logic [CW-1:0] center_calc(input logic [7:0] l,
                                                input logic [1:0] e);
    logic [1:0] ec;
    ec = (e == 2'h3) ? 2'h2 : e;
    return CW'(l * (NOM_STEP << ec));
  endfunction

  function automatic logic [WW-1:0] abs_diff(input logic [WW-1:0] a,
                                             input logic [WW-1:0] b);
    return (a > b) ? WW'(a - b) : WW'(b - a);
  endfunction
endpackage

// [hw/clock_generator_unit.sv]
// Purpose: crystal and pll clock generator with lock detection
// Assumes: XTAL_IN and VCO_CLOCK are sampled synchronous to REF_CLK
// Notes: generated clocks are flop outputs, edges on REF_CLK grid
// Summary of operation
// RULE1: crystal clock runs, reference is buffered copy
// RULE2: base clock is crystal/2 or vco/2
// RULE3: bus clock is half base clock
// RULE4: system clock from base or crystal clock
// RULE5: oscillator runs on request or stop bit
// RULE6: feedback clock is vco divided by N
// RULE7: phase detector emits up/down correction pulses
// RULE8: lock detector counts feedback per reference window
// RULE9: detector decides filter mode and lock
// RULE10: mode switching automatic or by software
// RULE11: interrupt on lock entry or exit
// RULE12: configuration bit keeps oscillator in stop
// RULE13: center frequency is step times L times 2^E; the code takes E=3 as E=2
// RULE14: bus frequency ceiling is 8 MHz
// RULE15: crystal logic uses edges, not duty cycle
// RULE16: auto mode makes tracking and lock read-only
// RULE17: auto mode interrupts on each lock toggle
// RULE18: manual mode: tracking writable, lock and irq off
// RULE19: software waits acquisition then lock time
// RULE20: source switch is glitch-free
// RULE21: lock status is synchronised before use
//
// Strobed register access and the address map were chosen for this implementation.
module clock_generator_unit
  import clkgen_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [AW-1:0] ADDR,
  input wire logic [DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DW-1:0] RDATA,
  input wire logic XTAL_IN,
  input wire logic VCO_CLOCK,
  input wire logic OSC_ENABLE_REQUEST,
  input wire logic SYS_FROM_CRYSTAL,
  output logic OSC_ENABLE,
  output logic CRYSTAL_CLOCK,
  output logic PLL_REF_CLOCK,
  output logic FINAL_REF_CLOCK,
  output logic VCO_FEEDBACK_CLOCK,
  output logic PUMP_UP,
  output logic PUMP_DOWN,
  output logic BASE_CLOCK_OUT,
  output logic BUS_CLOCK,
  output logic SYS_CLOCK,
  output logic LOCK,
  output logic TRACKING,
  output logic IRQ
);
  state_s s;
  state_s next_s;
  logic x_rise;
  logic r_rise;
  logic v_rise;
  logic f_rise;
  logic cur_div;
  logic [WW-1:0] cnt_now;
  logic [WW-1:0] dev;

  always_comb begin
    next_s = s;
    cnt_now = '0;
    dev = '0;
    x_rise = s.xclk & ~s.rclk;
    r_rise = s.rclk & ~s.rclk_d;
    v_rise = VCO_CLOCK & s.ctl.pwr & ~s.vco_d;
    f_rise = s.fb & ~s.fb_d;
    cur_div = s.sel_act ? s.vdiv : s.xdiv;
    // oscillator and crystal path
    next_s.osc_en = OSC_ENABLE_REQUEST | s.ctl.osc_stop; // [RULE5] [RULE12]
    next_s.xclk = XTAL_IN & s.osc_en; // [RULE1]
    next_s.rclk = s.xclk; // [RULE1]
    next_s.rclk_d = s.rclk;
    next_s.vco_d = VCO_CLOCK & s.ctl.pwr;
    next_s.fb_d = s.fb;
    next_s.base_d = s.base;
    // halving dividers toggle on rising edges only
    if (x_rise) begin
      next_s.xdiv = ~s.xdiv; // [RULE2] [RULE15]
    end
    if (v_rise) begin
      next_s.vdiv = ~s.vdiv; // [RULE2]
    end
    // modulo feedback divider
    if (s.mult_n <= NW'(1)) begin
      next_s.fb = next_s.vco_d; // [RULE6]
      next_s.fb_cnt = '0;
    end else if (v_rise) begin
      if (s.fb_cnt >= NW'(s.mult_n - NW'(1))) begin
        next_s.fb_cnt = '0;
        next_s.fb = 1'b1; // [RULE6]
      end else begin
        next_s.fb_cnt = NW'(s.fb_cnt + NW'(1));
        if (NW'(s.fb_cnt + NW'(1)) == (s.mult_n >> 1)) begin
          next_s.fb = 1'b0;
        end
      end
    end
    // phase-frequency detector
    if (!s.ctl.pwr) begin
      next_s.up = 1'b0;
      next_s.dn = 1'b0;
    end else if (r_rise && !f_rise) begin
      next_s.up = ~s.dn; // [RULE7]
      next_s.dn = 1'b0;
    end else if (f_rise && !r_rise) begin
      next_s.dn = ~s.up; // [RULE7]
      next_s.up = 1'b0;
    end
    // frequency lock detector
    if (!s.ctl.pwr) begin
      next_s.win_cnt = '0;
      next_s.edges = '0;
      next_s.trk_det = 1'b0;
      next_s.lock_det = 1'b0;
    end else begin
      cnt_now = s.edges;
      if (f_rise && s.edges != '1) begin
        cnt_now = WW'(s.edges + WW'(1)); // [RULE8]
      end
      next_s.edges = cnt_now;
      if (r_rise) begin
        if (s.win_cnt == WW'(LOCK_WIN - WW'(1))) begin
          dev = abs_diff(cnt_now, LOCK_WIN);
          next_s.trk_det = (dev <= TRACK_TOL); // [RULE9]
          next_s.lock_det = (dev <= LOCK_TOL); // [RULE9]
          next_s.win_cnt = '0;
          next_s.edges = '0;
        end else begin
          next_s.win_cnt = WW'(s.win_cnt + WW'(1));
        end
      end
    end
    // lock status crossing
    next_s.lock_s1 = s.lock_det; // [RULE21]
    next_s.lock_s2 = s.lock_s1; // [RULE21]
    next_s.lock_prev = s.lock_s2;
    next_s.lock_out = s.ctl.auto_bw & s.lock_s2; // [RULE16] [RULE18]
    next_s.trk_out = s.ctl.auto_bw ? s.trk_det : s.ctl.trk_wr; // [RULE10]
    // interrupt flag, set wins over clear
    if (WR && ADDR == REG_STATUS && WDATA[ST_FLAG]) begin
      next_s.irq_flag = 1'b0;
    end
    if (s.ctl.auto_bw && s.ctl.irq_en && s.lock_s2 != s.lock_prev) begin
      next_s.irq_flag = 1'b1; // [RULE11] [RULE17]
    end
    next_s.irq = s.irq_flag & s.ctl.irq_en & s.ctl.auto_bw; // [RULE18]
    // glitch-free base selector: swap only while the active side is low
    next_s.base = s.hold ? 1'b0 : cur_div; // [RULE2]
    if (!s.hold && s.ctl.bsel != s.sel_act && !cur_div) begin
      next_s.sel_act = s.ctl.bsel; // [RULE20]
      next_s.hold = 1'b1;
    end else if (s.hold && !cur_div) begin
      next_s.hold = 1'b0; // [RULE20]
    end
    if (s.base && !s.base_d) begin
      next_s.bus = ~s.bus; // [RULE3]
    end
    next_s.sys = SYS_FROM_CRYSTAL ? s.xclk : s.base; // [RULE4]
    next_s.center = center_calc(s.lin_l, s.exp_e); // [RULE13]
    next_s.over = s.center > VCO_MAX; // [RULE14]
    // register writes
    if (WR) begin
      unique case (ADDR)
        REG_CTRL: begin
          next_s.ctl = ctrl_s'(WDATA[CTL_W-1:0]);
          if (s.ctl.auto_bw) begin
            next_s.ctl.trk_wr = s.ctl.trk_wr; // [RULE16]
          end
        end
        REG_MULT: next_s.mult_n = WDATA[NW-1:0];
        REG_RANGE: begin
          next_s.lin_l = WDATA[7:0];
          next_s.exp_e = WDATA[RNG_E_LSB+1:RNG_E_LSB];
        end
        default: begin
        end
      endcase
    end
    // register reads, data stand one cycle later
    next_s.rdata = '0;
    if (RD) begin
      unique case (ADDR)
        REG_CTRL: next_s.rdata = DW'(s.ctl);
        REG_MULT: next_s.rdata = DW'(s.mult_n);
        REG_RANGE: next_s.rdata = DW'({s.exp_e, s.lin_l});
        REG_STATUS: begin
          next_s.rdata[ST_LOCK] = s.lock_out;
          next_s.rdata[ST_TRK] = s.trk_out;
          next_s.rdata[ST_FLAG] = s.irq_flag;
          next_s.rdata[ST_SEL] = s.sel_act;
          next_s.rdata[ST_OVER] = s.over;
        end
        REG_CENTER: next_s.rdata = DW'(s.center);
        default: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
      s.ctl <= ctrl_s'(CTRL_RST);
      s.mult_n <= MULT_RST;
      s.lin_l <= LIN_RST;
      s.exp_e <= EXP_RST;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA = s.rdata;
  assign OSC_ENABLE = s.osc_en;
  assign CRYSTAL_CLOCK = s.xclk;
  assign PLL_REF_CLOCK = s.rclk;
  assign FINAL_REF_CLOCK = s.rclk;
  assign VCO_FEEDBACK_CLOCK = s.fb;
  assign PUMP_UP = s.up;
  assign PUMP_DOWN = s.dn;
  assign BASE_CLOCK_OUT = s.base;
  assign BUS_CLOCK = s.bus;
  assign SYS_CLOCK = s.sys;
  assign LOCK = s.lock_out;
  assign TRACKING = s.trk_out;
  assign IRQ = s.irq;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  AST_REF_BUFFER: assert property ( // [RULE1]
    PLL_REF_CLOCK == $past(CRYSTAL_CLOCK, 1))
    else $error("reference clock is not a copy of crystal clock");
  AST_OSC_RUN: assert property ( // [RULE5]
    (OSC_ENABLE_REQUEST || s.ctl.osc_stop) |=> OSC_ENABLE)
    else $error("oscillator not enabled on request");
  AST_BUS_HALF: assert property ( // [RULE3]
    (s.base && !s.base_d) |=> (BUS_CLOCK != $past(BUS_CLOCK)))
    else $error("bus clock missed a base clock edge");
  AST_SWITCH_QUIET: assert property ( // [RULE20]
    (s.sel_act != $past(s.sel_act)) |-> ##1 !BASE_CLOCK_OUT)
    else $error("base clock not held low across source switch");
  AST_FB_WRAP: assert property ( // [RULE6]
    (v_rise && s.mult_n > 8'h01 && s.fb_cnt == NW'(s.mult_n - 8'h01))
    |=> (VCO_FEEDBACK_CLOCK && s.fb_cnt == '0))
    else $error("feedback divider did not wrap at N");
  AST_PUMP_EXCL: assert property ( // [RULE7]
    !(PUMP_UP && PUMP_DOWN))
    else $error("up and down pulses at once");
  AST_LOCK_SYNC: assert property ( // [RULE21]
    $rose(s.lock_det) |-> ##2 s.lock_s2)
    else $error("lock status not through two stages");
  AST_MANUAL_QUIET: assert property ( // [RULE18]
    (!s.ctl.auto_bw)[*2] |=> (!LOCK && !IRQ))
    else $error("lock or interrupt active in manual mode");
  AST_IRQ_TOGGLE: assert property ( // [RULE17]
    (s.ctl.auto_bw && s.ctl.irq_en && s.lock_s2 != s.lock_prev)
    |=> s.irq_flag ##1 IRQ)
    else $error("lock toggle did not raise interrupt");
  AST_CENTER_UNIT: assert property ( // [RULE13]
    (s.lin_l == 8'h01 && s.exp_e == 2'h0)[*2] |-> s.center == 20'h002CA)
    else $error("center frequency wrong for L=1 E=0");

  COV_LOCKED: cover property ($rose(LOCK));
  COV_SWITCH: cover property ($rose(s.sel_act) ##[1:40] BASE_CLOCK_OUT);
  COV_IRQ: cover property ($rose(IRQ));
endmodule // clock_generator_unit

// [tb/clock_source.sv]
// Purpose: crystal and vco source model for the clock generator
// Assumes: levels change right after a REF_CLK rising edge
// Notes: both sources run free; crystal duty is uneven
module clock_source (
  input wire logic ref_clk,
  input wire logic [7:0] vco_half,
  output logic xtal,
  output logic vco
);
  timeunit 1ns;
  timeprecision 1ps;
  int xc = 0;
  int vc = 0;
  initial xtal = 1'b0;
  initial vco = 1'b0;
  // crystal high 5, low 3 cycles: consumers must not need 50% duty
  always @(posedge ref_clk) begin
    xc <= (xc == 7) ? 0 : xc + 1;
    xtal <= (xc < 5);
    vc <= (vc + 1 >= vco_half) ? 0 : vc + 1;
    if (vc + 1 >= vco_half) vco <= ~vco;
  end
endmodule // clock_source

// [tb/crystal_pll_clock_generator_bench.sv]
// Purpose: self-checking bench for the clock generator unit
// Assumes: crystal period 8 cycles, vco period 2*vco_half cycles
// Notes: edge counts are taken at the falling edge, one-edge slack
module crystal_pll_clock_generator_bench
  import clkgen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK, RST_B, WR, RD, XTAL_IN, VCO_CLOCK;
  logic OSC_ENABLE_REQUEST, SYS_FROM_CRYSTAL, OSC_ENABLE, CRYSTAL_CLOCK;
  logic PLL_REF_CLOCK, FINAL_REF_CLOCK, VCO_FEEDBACK_CLOCK, PUMP_UP;
  logic PUMP_DOWN, BASE_CLOCK_OUT, BUS_CLOCK, SYS_CLOCK, LOCK, TRACKING, IRQ;
  logic [AW-1:0] ADDR;
  logic [DW-1:0] WDATA, RDATA;
  logic [7:0] vco_half;
  logic [6:0] prev = '0;
  logic pipe_on = 1'b0;
  int cnt [7];
  int bad_count = 0;
  int checks = 0;
  int c;
  logic [7:0] l_t [4] = '{8'h01, 8'h03, 8'h05, 8'hFF};
  logic [1:0] e_t [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  wire logic [6:0] now = {CRYSTAL_CLOCK, BASE_CLOCK_OUT, BUS_CLOCK,
    SYS_CLOCK, VCO_FEEDBACK_CLOCK, VCO_CLOCK, PUMP_UP | PUMP_DOWN};

  clock_generator_unit DUT (.REF_CLK, .RST_B, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .XTAL_IN, .VCO_CLOCK, .OSC_ENABLE_REQUEST, .SYS_FROM_CRYSTAL,
    .OSC_ENABLE, .CRYSTAL_CLOCK, .PLL_REF_CLOCK, .FINAL_REF_CLOCK,
    .VCO_FEEDBACK_CLOCK, .PUMP_UP, .PUMP_DOWN, .BASE_CLOCK_OUT, .BUS_CLOCK,
    .SYS_CLOCK, .LOCK, .TRACKING, .IRQ);
  clock_source src (.ref_clk(REF_CLK), .vco_half(vco_half), .xtal(XTAL_IN),
    .vco(VCO_CLOCK));

  task automatic chk(string nm, logic [DW-1:0] seen, logic [DW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic near(string nm, int seen, int exp);
    chk(nm, DW'((seen <= exp + 1 && seen >= exp - 1) ? exp : seen), DW'(exp));
  endtask
  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge REF_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e, string nm);
    @(posedge REF_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 chk(nm, RDATA, e);
  endtask
  task automatic meas(int n);
    for (int k = 0; k < 7; k++) cnt[k] = 0;
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic wait_lock(logic v);
    for (int i = 0; i < 3000; i++) begin
      @(posedge REF_CLK);
      #1;
      if (LOCK === v) break;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  always @(negedge REF_CLK) begin
    for (int k = 0; k < 7; k++) if (now[k] && !prev[k]) cnt[k]++;
    if (pipe_on) chk("ref_copy", PLL_REF_CLOCK, prev[6]);
    if (pipe_on) chk("final_ref", FINAL_REF_CLOCK, prev[6]);
    chk("pump_both", PUMP_UP & PUMP_DOWN, 0);
    prev = now;
  end
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    RST_B = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = '0;
    WDATA = '0;
    OSC_ENABLE_REQUEST = 1'b0;
    SYS_FROM_CRYSTAL = 1'b0;
    vco_half = 8'h02;
    repeat (3) @(posedge REF_CLK);
    RST_B <= 1'b1;
    rd(REG_CTRL, 32'h04, "ctrl_rst");
    rd(REG_MULT, 32'h01, "mult_rst");
    rd(REG_CENTER, 32'h0, "center_rst");
    wr(3'h7, 32'hFF);
    rd(3'h7, 32'h0, "unmapped");
    @(posedge REF_CLK);
    #1 chk("rdata_idle", RDATA, 0);
    meas(64);
    near("xtal_off", cnt[6], 0);
    chk("osc_off", OSC_ENABLE, 0);
    wr(REG_CTRL, 32'h24);
    meas(512);
    near("xtal_stop", cnt[6], 64);
    near("base_x", cnt[5], 32);
    near("bus", cnt[4], 16);
    near("sys_base", cnt[3], 32);
    pipe_on = 1'b1;
    @(posedge REF_CLK);
    OSC_ENABLE_REQUEST <= 1'b1;
    SYS_FROM_CRYSTAL <= 1'b1;
    wr(REG_CTRL, 32'h04);
    meas(512);
    chk("osc_req", OSC_ENABLE, 1);
    near("sys_x", cnt[3], 64);
    @(posedge REF_CLK);
    SYS_FROM_CRYSTAL <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      c = l_t[i] * 714 * ((e_t[i] == 2'h3) ? 4 : (1 << e_t[i]));
      wr(REG_RANGE, {22'h0, e_t[i], l_t[i]});
      rd(REG_CENTER, DW'(c), "center");
      rd(REG_STATUS, DW'(c > 320000) << 4, "over");
    end
    wr(REG_RANGE, 32'h0);
    wr(REG_MULT, 32'h02);
    wr(REG_CTRL, 32'h15);
    wait_lock(1'b1);
    chk("lock", LOCK, 1);
    chk("trk", TRACKING, 1);
    repeat (2) @(posedge REF_CLK);
    #1 chk("irq_in", IRQ, 1);
    rd(REG_STATUS, 32'h07, "status_lock");
    meas(512);
    near("fb_div", cnt[2], 64);
    near("vco", cnt[1], 128);
    wr(REG_STATUS, 32'h04);
    repeat (2) @(posedge REF_CLK);
    #1 chk("irq_clr", IRQ, 0);
    vco_half <= 8'h03;
    wait_lock(1'b0);
    chk("unlock", LOCK, 0);
    meas(64);
    chk("pumps", DW'(cnt[0] > 0), 1);
    chk("irq_out", IRQ, 1);
    vco_half <= 8'h02;
    wait_lock(1'b1);
    wr(REG_STATUS, 32'h04);
    wr(REG_CTRL, 32'h07);
    repeat (16) @(posedge REF_CLK);
    meas(512);
    near("base_v", cnt[5], 64);
    rd(REG_STATUS, 32'h0B, "status_sel");
    wr(REG_CTRL, 32'h11);
    repeat (8) @(posedge REF_CLK);
    wr(REG_CTRL, 32'h19);
    vco_half <= 8'h03;
    repeat (600) @(posedge REF_CLK);
    #1 chk("man_trk", TRACKING, 1);
    chk("man_lock", LOCK, 0);
    chk("man_irq", IRQ, 0);
    wr(REG_CTRL, 32'h11);
    repeat (4) @(posedge REF_CLK);
    #1 chk("man_wide", TRACKING, 0);
    wr(REG_CTRL, 32'h04);
    wr(REG_CTRL, 32'h0C);
    rd(REG_CTRL, 32'h04, "auto_ro");
    end_of_test();
  end
endmodule // crystal_pll_clock_generator_bench
